//--- tcb_pin_model.sv
// Model of the external pin sources around the timer/counter block
`timescale 1ns/1ps
`default_nettype none

module tcb_pin_model (
    input  wire logic       sys_clk_i,
    input  wire logic [5:0] fall_req_i,
    output logic      [5:0] pin_o
);
    // Pin lanes: 0 ext zero, 1 ext one, 2 t0, 3 t1, 4 t2, 5 t2 trigger; idle high on pull-ups
    logic [5:0] cnt_ff [6];

    initial begin
        pin_o = 6'h3f;
        for (int i = 0; i < 6; i++) begin
            cnt_ff[i] = 6'h00;
        end
    end

    always @(posedge sys_clk_i) begin
        for (int i = 0; i < 6; i++) begin
            if (fall_req_i[i] && cnt_ff[i] == 6'h00) begin
                cnt_ff[i] <= 6'h30;
            end else if (cnt_ff[i] != 6'h00) begin
                cnt_ff[i] <= cnt_ff[i] - 6'h01;
            end
            // Low for two machine cycles, then released high for two more
            pin_o[i] <= !(cnt_ff[i] > 6'h18);
        end
    end
endmodule

`default_nettype wire

//--- tcb_pkg.sv
// Constants and types of the timer/counter block
package tcb_pkg;

    // Register addresses
    localparam logic [7:0] TCB_A_TIMER_CONTROL  = 8'h88;
    localparam logic [7:0] TCB_A_TMOD  = 8'h89;
    localparam logic [7:0] TCB_A_TL0   = 8'h8a;
    localparam logic [7:0] TCB_A_TL1   = 8'h8b;
    localparam logic [7:0] TCB_A_TH0   = 8'h8c;
    localparam logic [7:0] TCB_A_TH1   = 8'h8d;
    localparam logic [7:0] TCB_A_TIMER_TWO_CONTROL = 8'hc8;
    localparam logic [7:0] TCB_A_RCL   = 8'hca;
    localparam logic [7:0] TCB_A_RCH   = 8'hcb;
    localparam logic [7:0] TCB_A_TL2   = 8'hcc;
    localparam logic [7:0] TCB_A_TH2   = 8'hcd;

    localparam logic [7:0] TCB_RST_VAL = 8'h00;

    // timer_control bits
    localparam int TC_TF1 = 7;
    localparam int TC_TR1 = 6;
    localparam int TC_TF0 = 5;
    localparam int TC_TR0 = 4;
    localparam int TC_IE1 = 3;
    localparam int TC_IT1 = 2;
    localparam int TC_IE0 = 1;
    localparam int TC_IT0 = 0;

    // Mode register bits
    localparam int TM_GATE1 = 7;
    localparam int TM_CT1   = 6;
    localparam int TM_M1LSB = 4;
    localparam int TM_GATE0 = 3;
    localparam int TM_CT0   = 2;
    localparam int TM_M0LSB = 0;

    localparam logic [1:0] TCB_M_13BIT = 2'h0;
    localparam logic [1:0] TCB_M_16BIT = 2'h1;
    localparam logic [1:0] TCB_M_RLD8  = 2'h2;
    localparam logic [1:0] TCB_M_SPLIT = 2'h3;

    // timer_two_control bits
    localparam int T2_TF2   = 7;
    localparam int T2_TIMER_TWO_EXTERNAL_FLAG  = 6;
    localparam int T2_RCLK  = 5;
    localparam int T2_TX_BAUD_CLOCK_SELECT  = 4;
    localparam int T2_TIMER_TWO_EXTERNAL_ENABLE = 3;
    localparam int T2_TR2   = 2;
    localparam int T2_CT2   = 1;
    localparam int T2_CAPTURE_SELECT  = 0;

    // Acknowledge lanes
    localparam int ACK_IE0 = 0;
    localparam int ACK_TF0 = 1;
    localparam int ACK_IE1 = 2;
    localparam int ACK_TF1 = 3;

    // Machine cycle of twelve core clocks
    localparam int         TCB_MCYC_CLKS = 12;
    localparam logic [3:0] TCB_MCYC_LAST = 4'(TCB_MCYC_CLKS - 1);

    typedef enum logic [1:0] {T2_OFF, T2_AUTO, T2_CAPT, T2_BAUD} tcb_t2_mode_e;

endpackage

//--- tcb_testbench.sv
// Self-checking bench of the timer/counter block
`timescale 1ns/1ps
`default_nettype none

module testbench;
    import tcb_pkg::*;
    logic       clk, rstn, wr, tf0, tf1, ie0, ie1, t2irq, btick;
    logic [7:0] addr, wdata, rdata, th, tl, tl_a, th_a, mv;
    logic [3:0] ack;
    logic [5:0] req, pin;
    int         errors, n_tests, seed, cyc, r, k, n, exp, tmr, md;

    tcb_timer_counter dut (.sys_clk_i(clk), .rstn_i(rstn), .sfr_addr_i(addr), .sfr_wr_i(wr),
        .sfr_wdata_i(wdata), .sfr_rdata_o(rdata), .ext_irq_pin_zero_i(pin[0]), .ext_irq_pin_one_i(pin[1]),
        .t0_count_pin_i(pin[2]), .t1_count_pin_i(pin[3]), .t2_count_pin_i(pin[4]),
        .timer_two_trigger_pin_i(pin[5]), .irq_ack_i(ack), .timer_zero_overflow_flag_o(tf0),
        .timer_one_overflow_flag_o(tf1), .ext_irq_zero_flag_o(ie0), .ext_irq_one_flag_o(ie1),
        .timer_two_irq_o(t2irq), .t2_baud_tick_o(btick));
    tcb_pin_model pins (.sys_clk_i(clk), .fall_req_i(req), .pin_o(pin));

    initial begin
        clk = 1'b0;
        forever #12.5 clk = ~clk;
    end

    always @(posedge clk) begin
        cyc <= cyc + 1;
        if (cyc == 20000) begin
            errors++;
            stop_test();
        end
    end

    ////////////////////////////////////////////////////////////////////////////////
    task automatic stop_test();
        if (errors == 0 && n_tests > 0) begin
            $display("All checks passed");
        end else begin
            $display("Checks failed");
        end
        $finish;
    endtask

    task automatic chk8(input string nm, input logic [7:0] e, input logic [7:0] g);
        n_tests++;
        if (g !== e) begin
            $display("wrong value %s expected %h seen %h", nm, e, g);
            errors++;
        end
    endtask

    task automatic chk1(input string nm, input logic e, input logic g);
        n_tests++;
        if (g !== e) begin
            $display("wrong value %s expected %b seen %b", nm, e, g);
            errors++;
        end
    endtask

    task automatic wr_reg(input logic [7:0] a, input logic [7:0] d);
        @(posedge clk);
        addr <= a;
        wdata <= d;
        wr <= 1'b1;
        @(posedge clk);
        wr <= 1'b0;
    endtask

    task automatic chk_rd(input logic [7:0] a, input logic [7:0] e, input string nm);
        @(posedge clk);
        addr <= a;
        @(posedge clk);
        @(negedge clk);
        chk8(nm, e, rdata);
    endtask

    task automatic pulse(input logic [5:0] m);
        @(posedge clk);
        req <= m;
        @(posedge clk);
        req <= 6'h00;
    endtask

    task automatic ack_pulse(input logic [3:0] m);
        @(posedge clk);
        ack <= m;
        @(posedge clk);
        ack <= 4'h0;
        #1;
    endtask

    // Count model of timers 0 and 1: overflow above a 16-bit {high, low} value
    function automatic int t01_model(int md, int h, int l, int k);
        int v = h * 256 + l;
        int ovf = 0;
        for (int i = 0; i < k; i++) begin
            if (md == 1) begin
                v = (v + 1) % 65536;
                ovf = ovf | int'(v == 0);
            end else begin
                v = ((v % 256) == 255) ? h * 257 : v + 1;
                ovf = ovf | int'((v % 256) == h && (v / 256) == h);
            end
        end
        return ovf * 65536 + v;
    endfunction

    function automatic logic get_ie(int i);
        return i ? ie1 : ie0;
    endfunction

    ////////////////////////////////////////////////////////////////////////////////
    initial begin
        logic [7:0] regs [12] = '{TCB_A_TIMER_CONTROL, TCB_A_TMOD, TCB_A_TL0, TCB_A_TL1, TCB_A_TH0, TCB_A_TH1,
            TCB_A_TIMER_TWO_CONTROL, TCB_A_RCL, TCB_A_RCH, TCB_A_TL2, TCB_A_TH2, 8'h99};
        errors = 0;
        n_tests = 0;
        seed = 38;
        cyc = 0;
        rstn = 1'b0;
        addr = 8'h00;
        wdata = 8'h00;
        wr = 1'b0;
        ack = 4'h0;
        req = 6'h00;
        repeat (10) @(posedge clk);
        rstn <= 1'b1;
        foreach (regs[i]) chk_rd(regs[i], TCB_RST_VAL, "reset value");
        for (int i = 2; i < 11; i++) begin
            if (i == 6) continue;
            r = $random(seed);
            wr_reg(regs[i], 8'(r));
            chk_rd(regs[i], 8'(r), "byte register");
        end
        // Timers 0 and 1 in modes 1 and 2; the counter select bit freezes the count
        for (int c = 0; c < 4; c++) begin
            tmr = c % 2;
            md = c / 2 + 1;
            tl_a = tmr ? TCB_A_TL1 : TCB_A_TL0;
            th_a = tmr ? TCB_A_TH1 : TCB_A_TH0;
            r = $random(seed) & 15;
            th = (md == 1) ? 8'hff : 8'hc0 | 8'(r);
            tl = (md == 1) ? 8'he0 | 8'(r) : 8'hfa;
            k = 40 + r;
            mv = 8'(md << (tmr * 4));
            wr_reg(TCB_A_TIMER_CONTROL, 8'h00);
            wr_reg(TCB_A_TMOD, mv);
            wr_reg(th_a, th);
            wr_reg(tl_a, tl);
            repeat (30) @(posedge clk);
            chk_rd(tl_a, tl, "stopped low byte");
            exp = t01_model(md, th, tl, k);
            wr_reg(TCB_A_TIMER_CONTROL, tmr ? 8'h40 : 8'h10);
            repeat (12 * k - 2) @(posedge clk);
            wr_reg(TCB_A_TMOD, mv | 8'(8'h04 << (tmr * 4)));
            chk_rd(tl_a, 8'(exp), "low byte count");
            chk_rd(th_a, 8'(exp / 256), "high byte count");
            chk1("overflow flag", exp[16], tmr ? tf1 : tf0);
            ack_pulse(tmr ? 4'h8 : 4'h2);
            chk1("flag after ack", 1'b0, tmr ? tf1 : tf0);
        end
        // External interrupts: one pin edge-triggered, the other level-triggered
        for (int m = 0; m < 2; m++) begin
            wr_reg(TCB_A_TIMER_CONTROL, m ? 8'h04 : 8'h01);
            pulse(6'h03);
            repeat (3) @(posedge clk);
            #1;
            chk1("edge flag set", 1'b1, get_ie(m));
            chk1("level flag set", 1'b1, get_ie(1 - m));
            ack_pulse(4'h5);
            chk1("edge flag acked", 1'b0, get_ie(m));
            chk1("level flag kept", 1'b1, get_ie(1 - m));
            // Pin sources stay busy for four machine cycles after a request
            repeat (50) @(posedge clk);
            #1;
            chk1("level flag follows pin", 1'b0, get_ie(1 - m));
        end
        // Event counting on the t0 and t1 pins
        wr_reg(TCB_A_TMOD, 8'h55);
        wr_reg(TCB_A_TL0, 8'h00);
        wr_reg(TCB_A_TL1, 8'h00);
        wr_reg(TCB_A_TIMER_CONTROL, 8'h50);
        n = 2 + ($random(seed) & 3);
        repeat (n) begin
            pulse(6'h0c);
            repeat (50) @(posedge clk);
        end
        chk_rd(TCB_A_TL0, 8'(n), "t0 events");
        chk_rd(TCB_A_TL1, 8'(n), "t1 events");
        // Gated timer zero misses the two machine ticks while its pin is low
        wr_reg(TCB_A_TIMER_CONTROL, 8'h00);
        wr_reg(TCB_A_TMOD, 8'h09);
        wr_reg(TCB_A_TH0, 8'h00);
        wr_reg(TCB_A_TL0, 8'h00);
        wr_reg(TCB_A_TIMER_CONTROL, 8'h10);
        pulse(6'h01);
        repeat (12 * 20 - 4) @(posedge clk);
        wr_reg(TCB_A_TIMER_CONTROL, 8'h00);
        chk_rd(TCB_A_TL0, 8'(20 - 2), "gated count");
        // Timer two autoreload, off, external reload, capture, baud
        r = $random(seed) & 8'h7f;
        wr_reg(TCB_A_TL2, 8'hfe);
        wr_reg(TCB_A_TH2, 8'hff);
        wr_reg(TCB_A_RCL, 8'(r));
        wr_reg(TCB_A_RCH, 8'h12);
        wr_reg(TCB_A_TIMER_TWO_CONTROL, 8'h04);
        repeat (12 * 5 - 2) @(posedge clk);
        #1;
        chk1("t2 overflow irq", 1'b1, t2irq);
        wr_reg(TCB_A_TIMER_TWO_CONTROL, 8'h00);
        repeat (30) @(posedge clk);
        chk_rd(TCB_A_TL2, 8'(r + 3), "t2 after reload");
        chk_rd(TCB_A_TH2, 8'h12, "t2 high reload");
        wr_reg(TCB_A_TIMER_TWO_CONTROL, 8'h0e);
        wr_reg(TCB_A_TL2, 8'h99);
        pulse(6'h20);
        repeat (50) @(posedge clk);
        chk_rd(TCB_A_TL2, 8'(r), "t2 external reload");
        chk1("t2 external irq", 1'b1, t2irq);
        wr_reg(TCB_A_TIMER_TWO_CONTROL, 8'h0f);
        wr_reg(TCB_A_TL2, 8'h3c);
        pulse(6'h20);
        repeat (30) @(posedge clk);
        chk_rd(TCB_A_RCL, 8'h3c, "captured low");
        chk_rd(TCB_A_RCH, 8'h12, "captured high");
        chk_rd(TCB_A_TIMER_TWO_CONTROL, 8'h4f, "capture flags");
        wr_reg(TCB_A_TIMER_TWO_CONTROL, 8'h0f);
        wr_reg(TCB_A_TL2, 8'hff);
        wr_reg(TCB_A_TH2, 8'hff);
        pulse(6'h10);
        repeat (60) @(posedge clk);
        chk_rd(TCB_A_TIMER_TWO_CONTROL, 8'h8f, "capture overflow");
        chk_rd(TCB_A_TL2, 8'h00, "capture count");
        wr_reg(TCB_A_TIMER_TWO_CONTROL, 8'h00);
        wr_reg(TCB_A_RCL, 8'hfc);
        wr_reg(TCB_A_RCH, 8'hff);
        wr_reg(TCB_A_TL2, 8'hfc);
        wr_reg(TCB_A_TH2, 8'hff);
        wr_reg(TCB_A_TIMER_TWO_CONTROL, 8'h1c);
        n = 0;
        repeat (40) begin
            @(posedge clk);
            #1;
            if (btick === 1'b1) n++;
        end
        chk1("baud ticks", 1'b1, n >= 4);
        pulse(6'h20);
        repeat (30) @(posedge clk);
        chk_rd(TCB_A_TIMER_TWO_CONTROL, 8'h5c, "baud flags");
        chk1("baud external irq", 1'b1, t2irq);
        stop_test();
    end
endmodule

`default_nettype wire

//--- tcb_timer_counter.sv
// Timer/counter block: timers 0, 1, 2 and external interrupt flags
`timescale 1ns/1ps
`default_nettype none

// Function
// - Timer one overflow sets bit 7; vectoring clears it
// - Bit 6 runs timer one when set, stops it when clear
// - Timer zero overflow sets bit 5; vectoring clears it
// - Bit 4 runs timer zero when set, halts it when clear
// - Bit 3 set by edge or low on pin one; edge flag cleared on vectoring
// - Bit 1 set by edge or low on pin zero; edge flag cleared on vectoring
// - Level flags follow the pin and are not cleared on vectoring
// - Bits 2 and 0: one selects falling edge, zero selects low level
// - Timers 0 and 1 have high and low bytes, cascaded by mode; timer zero splits in mode 3, timer one halts
// - Timer two mode: off, baud, capture or autoreload from control bits
// - Autoreload rollover sets overflow flag and reloads from reload bytes
// - Autoreload with external enable: trigger fall reloads and sets external flag
// - Capture mode counts 16 bits; overflow sets overflow flag
// - Capture with external enable: trigger fall copies count, sets external flag
// - External flag requests interrupts like the overflow flag
// - Baud mode never sets the timer two overflow flag
// - Baud mode trigger fall still sets external flag
// - Timer function counts once per twelve-clock machine cycle; timer two in baud mode counts every second clock
// - Counter function counts a high sample then a low sample
// - Gating bit makes a timer count only while its pin is high
module tcb_timer_counter
    import tcb_pkg::*;
(
    input  wire logic       sys_clk_i,
    input  wire logic       rstn_i,
    input  wire logic [7:0] sfr_addr_i,
    input  wire logic       sfr_wr_i,
    input  wire logic [7:0] sfr_wdata_i,
    output logic      [7:0] sfr_rdata_o,
    input  wire logic       ext_irq_pin_zero_i,
    input  wire logic       ext_irq_pin_one_i,
    input  wire logic       t0_count_pin_i,
    input  wire logic       t1_count_pin_i,
    input  wire logic       t2_count_pin_i,
    input  wire logic       timer_two_trigger_pin_i,
    input  wire logic [3:0] irq_ack_i,
    output logic            timer_zero_overflow_flag_o,
    output logic            timer_one_overflow_flag_o,
    output logic            ext_irq_zero_flag_o,
    output logic            ext_irq_one_flag_o,
    output logic            timer_two_irq_o,
    output logic            t2_baud_tick_o
);

    ////////////////////////////////////////////////////////////////////////
    // Count step for timers 0 and 1: {overflow, high, low}

    function automatic logic [16:0] tc_step(input logic [1:0] m,
                                            input logic [7:0] l,
                                            input logic [7:0] h,
                                            input logic       e);
        logic [12:0] c;
        logic [16:0] r;
        c = {h, l[4:0]} + 13'd1;
        r = {1'b0, h, l};
        if (e) begin
            case (m)
                TCB_M_13BIT: r = {&{h, l[4:0]}, c[12:5], l[7:5], c[4:0]};
                TCB_M_16BIT: r = {1'b0, h, l} + 17'd1;
                TCB_M_RLD8:  r = {&l, h, (&l) ? h : l + 8'd1};
                default:     r = {&l, h, l + 8'd1};
            endcase
        end
        return r;
    endfunction

    ////////////////////////////////////////////////////////////////////////
    // State

    logic [7:0] timer_control_ff, tmod_ff, tl0_ff, th0_ff, tl1_ff, th1_ff;
    logic [7:0] timer_two_control_ff, rcl_ff, rch_ff, tl2_ff, th2_ff, rdata_ff;
    logic [3:0] pre_ff;
    logic       half_ff, baud_ff;
    logic       smp0_ff, smp1_ff, smp2_ff, ext_irq_pin_zero_q_ff, ext_irq_pin_one_q_ff, timer_two_trigger_pin_q_ff;

    logic [7:0] nxt_timer_control, nxt_tmod, nxt_tl0, nxt_th0, nxt_tl1, nxt_th1;
    logic [7:0] nxt_timer_two_control, nxt_rcl, nxt_rch, nxt_tl2, nxt_th2, nxt_rdata;
    logic [3:0] nxt_pre;
    logic       nxt_half, nxt_baud;

    logic         mtick, t0_fall, t1_fall, t2_fall, ext_irq_pin_zero_fall, ext_irq_pin_one_fall;
    logic         ext2, en0, en1, en2, tick2, ovf0, ovf1, ovf2;
    logic [1:0]   m0, m1;
    logic [16:0]  r0, r1, c2;
    tcb_t2_mode_e t2_mode;

    ////////////////////////////////////////////////////////////////////////
    // Next-state logic

    always_comb begin
        m0 = tmod_ff[TM_M0LSB +: 2];
        m1 = tmod_ff[TM_M1LSB +: 2];
        mtick = (pre_ff == TCB_MCYC_LAST);
        nxt_pre = mtick ? 4'h0 : pre_ff + 4'h1;
        nxt_half = ~half_ff;
        t0_fall = mtick & smp0_ff & ~t0_count_pin_i;
        t1_fall = mtick & smp1_ff & ~t1_count_pin_i;
        t2_fall = mtick & smp2_ff & ~t2_count_pin_i;
        ext_irq_pin_zero_fall = ext_irq_pin_zero_q_ff & ~ext_irq_pin_zero_i;
        ext_irq_pin_one_fall = ext_irq_pin_one_q_ff & ~ext_irq_pin_one_i;

        // Timers 0 and 1
        en0 = timer_control_ff[TC_TR0] & (~tmod_ff[TM_GATE0] | ext_irq_pin_zero_i)
            & (tmod_ff[TM_CT0] ? t0_fall : mtick);
        en1 = timer_control_ff[TC_TR1] & (~tmod_ff[TM_GATE1] | ext_irq_pin_one_i)
            & (tmod_ff[TM_CT1] ? t1_fall : mtick) & (m1 != TCB_M_SPLIT);
        r0 = tc_step(m0, tl0_ff, th0_ff, en0);
        r1 = tc_step(m1, tl1_ff, th1_ff, en1);
        ovf0 = r0[16];
        ovf1 = (m0 == TCB_M_SPLIT) ? (mtick & timer_control_ff[TC_TR1] & (&th0_ff)) : r1[16];
        nxt_tl0 = r0[7:0];
        nxt_th0 = r0[15:8];
        if (m0 == TCB_M_SPLIT && mtick && timer_control_ff[TC_TR1])
            nxt_th0 = th0_ff + 8'h01;
        nxt_tl1 = r1[7:0];
        nxt_th1 = r1[15:8];

        // Timer 2
        if (!timer_two_control_ff[T2_TR2])
            t2_mode = T2_OFF;
        else if (timer_two_control_ff[T2_RCLK] | timer_two_control_ff[T2_TX_BAUD_CLOCK_SELECT])
            t2_mode = T2_BAUD;
        else if (timer_two_control_ff[T2_CAPTURE_SELECT])
            t2_mode = T2_CAPT;
        else
            t2_mode = T2_AUTO;
        tick2 = timer_two_control_ff[T2_CT2] ? t2_fall : ((t2_mode == T2_BAUD) ? half_ff : mtick);
        en2 = (t2_mode != T2_OFF) & tick2;
        ext2 = timer_two_control_ff[T2_TIMER_TWO_EXTERNAL_ENABLE] & timer_two_trigger_pin_q_ff & ~timer_two_trigger_pin_i;
        c2 = {1'b0, th2_ff, tl2_ff} + {16'h0000, en2};
        ovf2 = c2[16];
        nxt_tl2 = c2[7:0];
        nxt_th2 = c2[15:8];
        nxt_rcl = rcl_ff;
        nxt_rch = rch_ff;
        nxt_baud = 1'b0;
        nxt_timer_two_control = timer_two_control_ff;
        case (t2_mode)
            T2_AUTO: begin
                if (ovf2 || ext2) begin
                    nxt_tl2 = rcl_ff;
                    nxt_th2 = rch_ff;
                end
            end
            T2_CAPT: begin
                if (ext2) begin
                    nxt_rcl = tl2_ff;
                    nxt_rch = th2_ff;
                end
            end
            T2_BAUD: begin
                if (ovf2) begin
                    nxt_tl2 = rcl_ff;
                    nxt_th2 = rch_ff;
                    nxt_baud = 1'b1;
                end
            end
            default: ;
        endcase

        // Register writes win over counting
        nxt_tmod = tmod_ff;
        nxt_timer_control = timer_control_ff;
        if (sfr_wr_i) begin
            case (sfr_addr_i)
                TCB_A_TIMER_CONTROL:  nxt_timer_control = sfr_wdata_i;
                TCB_A_TMOD:  nxt_tmod = sfr_wdata_i;
                TCB_A_TL0:   nxt_tl0 = sfr_wdata_i;
                TCB_A_TH0:   nxt_th0 = sfr_wdata_i;
                TCB_A_TL1:   nxt_tl1 = sfr_wdata_i;
                TCB_A_TH1:   nxt_th1 = sfr_wdata_i;
                TCB_A_TIMER_TWO_CONTROL: nxt_timer_two_control = sfr_wdata_i;
                TCB_A_RCL:   nxt_rcl = sfr_wdata_i;
                TCB_A_RCH:   nxt_rch = sfr_wdata_i;
                TCB_A_TL2:   nxt_tl2 = sfr_wdata_i;
                TCB_A_TH2:   nxt_th2 = sfr_wdata_i;
                default: ;
            endcase
        end

        // Acknowledge clears, then hardware sets win
        if (irq_ack_i[ACK_TF1])
            nxt_timer_control[TC_TF1] = 1'b0;
        if (irq_ack_i[ACK_TF0])
            nxt_timer_control[TC_TF0] = 1'b0;
        if (irq_ack_i[ACK_IE1] && timer_control_ff[TC_IT1])
            nxt_timer_control[TC_IE1] = 1'b0;
        if (irq_ack_i[ACK_IE0] && timer_control_ff[TC_IT0])
            nxt_timer_control[TC_IE0] = 1'b0;
        if (ovf1)
            nxt_timer_control[TC_TF1] = 1'b1;
        if (ovf0)
            nxt_timer_control[TC_TF0] = 1'b1;
        if (timer_control_ff[TC_IT1])
            nxt_timer_control[TC_IE1] = nxt_timer_control[TC_IE1] | ext_irq_pin_one_fall;
        else
            nxt_timer_control[TC_IE1] = ~ext_irq_pin_one_i;
        if (timer_control_ff[TC_IT0])
            nxt_timer_control[TC_IE0] = nxt_timer_control[TC_IE0] | ext_irq_pin_zero_fall;
        else
            nxt_timer_control[TC_IE0] = ~ext_irq_pin_zero_i;
        if (ovf2 && (t2_mode == T2_AUTO || t2_mode == T2_CAPT))
            nxt_timer_two_control[T2_TF2] = 1'b1;
        if (ext2)
            nxt_timer_two_control[T2_TIMER_TWO_EXTERNAL_FLAG] = 1'b1;

        // Read data, registered
        case (sfr_addr_i)
            TCB_A_TIMER_CONTROL:  nxt_rdata = timer_control_ff;
            TCB_A_TMOD:  nxt_rdata = tmod_ff;
            TCB_A_TL0:   nxt_rdata = tl0_ff;
            TCB_A_TH0:   nxt_rdata = th0_ff;
            TCB_A_TL1:   nxt_rdata = tl1_ff;
            TCB_A_TH1:   nxt_rdata = th1_ff;
            TCB_A_TIMER_TWO_CONTROL: nxt_rdata = timer_two_control_ff;
            TCB_A_RCL:   nxt_rdata = rcl_ff;
            TCB_A_RCH:   nxt_rdata = rch_ff;
            TCB_A_TL2:   nxt_rdata = tl2_ff;
            TCB_A_TH2:   nxt_rdata = th2_ff;
            default:     nxt_rdata = 8'h00;
        endcase
    end

    ////////////////////////////////////////////////////////////////////////
    // Registers

    always_ff @(posedge sys_clk_i) begin
        if (!rstn_i) begin
            timer_control_ff   <= TCB_RST_VAL;
            tmod_ff   <= TCB_RST_VAL;
            tl0_ff    <= TCB_RST_VAL;
            th0_ff    <= TCB_RST_VAL;
            tl1_ff    <= TCB_RST_VAL;
            th1_ff    <= TCB_RST_VAL;
            timer_two_control_ff  <= TCB_RST_VAL;
            rcl_ff    <= TCB_RST_VAL;
            rch_ff    <= TCB_RST_VAL;
            tl2_ff    <= TCB_RST_VAL;
            th2_ff    <= TCB_RST_VAL;
            rdata_ff  <= TCB_RST_VAL;
            pre_ff    <= 4'h0;
            half_ff   <= 1'b0;
            baud_ff   <= 1'b0;
            smp0_ff   <= 1'b0;
            smp1_ff   <= 1'b0;
            smp2_ff   <= 1'b0;
            ext_irq_pin_zero_q_ff <= 1'b0;
            ext_irq_pin_one_q_ff <= 1'b0;
            timer_two_trigger_pin_q_ff <= 1'b0;
        end else begin
            timer_control_ff   <= nxt_timer_control;
            tmod_ff   <= nxt_tmod;
            tl0_ff    <= nxt_tl0;
            th0_ff    <= nxt_th0;
            tl1_ff    <= nxt_tl1;
            th1_ff    <= nxt_th1;
            timer_two_control_ff  <= nxt_timer_two_control;
            rcl_ff    <= nxt_rcl;
            rch_ff    <= nxt_rch;
            tl2_ff    <= nxt_tl2;
            th2_ff    <= nxt_th2;
            rdata_ff  <= nxt_rdata;
            pre_ff    <= nxt_pre;
            half_ff   <= nxt_half;
            baud_ff   <= nxt_baud;
            if (mtick) begin
                smp0_ff <= t0_count_pin_i;
                smp1_ff <= t1_count_pin_i;
                smp2_ff <= t2_count_pin_i;
            end
            ext_irq_pin_zero_q_ff <= ext_irq_pin_zero_i;
            ext_irq_pin_one_q_ff <= ext_irq_pin_one_i;
            timer_two_trigger_pin_q_ff <= timer_two_trigger_pin_i;
        end
    end

    assign sfr_rdata_o = rdata_ff;
    assign timer_zero_overflow_flag_o = timer_control_ff[TC_TF0];
    assign timer_one_overflow_flag_o  = timer_control_ff[TC_TF1];
    assign ext_irq_zero_flag_o = timer_control_ff[TC_IE0];
    assign ext_irq_one_flag_o  = timer_control_ff[TC_IE1];
    assign timer_two_irq_o = timer_two_control_ff[T2_TF2] | timer_two_control_ff[T2_TIMER_TWO_EXTERNAL_FLAG];
    assign t2_baud_tick_o  = baud_ff;

    ////////////////////////////////////////////////////////////////////////
    // Assertions

    default clocking cb @(posedge sys_clk_i); endclocking
    default disable iff (!rstn_i);

    sequence s_trig_fall;
        timer_two_control_ff[T2_TIMER_TWO_EXTERNAL_ENABLE] && timer_two_trigger_pin_q_ff && !timer_two_trigger_pin_i;
    endsequence

    property p_tf1_set;
        ovf1 |=> timer_control_ff[TC_TF1];
    endproperty
    a_tf1_set: assert property (p_tf1_set) else $error("tf1 not set");

    property p_tf0_ack;
        irq_ack_i[ACK_TF0] && !ovf0 |=> !timer_control_ff[TC_TF0];
    endproperty
    a_tf0_ack: assert property (p_tf0_ack) else $error("tf0 not cleared");

    property p_t1_stop;
        !timer_control_ff[TC_TR1] && !sfr_wr_i |=> $stable(tl1_ff);
    endproperty
    a_t1_stop: assert property (p_t1_stop) else $error("tl1 moved");

    property p_t0_tick;
        mtick && timer_control_ff[TC_TR0] && m0 == TCB_M_16BIT && !tmod_ff[TM_CT0] && !tmod_ff[TM_GATE0]
            && !sfr_wr_i |=> tl0_ff == 8'($past(tl0_ff) + 8'h01);
    endproperty
    a_t0_tick: assert property (p_t0_tick) else $error("tl0 no step");

    property p_ie1_edge;
        timer_control_ff[TC_IT1] && ext_irq_pin_one_fall |=> timer_control_ff[TC_IE1];
    endproperty
    a_ie1_edge: assert property (p_ie1_edge) else $error("ie1 missed");

    property p_ie0_lvl;
        !timer_control_ff[TC_IT0] |=> timer_control_ff[TC_IE0] == !$past(ext_irq_pin_zero_i);
    endproperty
    a_ie0_lvl: assert property (p_ie0_lvl) else $error("ie0 level");

    property p_baud_no_tf2;
        t2_mode == T2_BAUD && !(sfr_wr_i && sfr_addr_i == TCB_A_TIMER_TWO_CONTROL)
            && !timer_two_control_ff[T2_TF2] |=> !timer_two_control_ff[T2_TF2];
    endproperty
    a_baud_no_tf2: assert property (p_baud_no_tf2) else $error("tf2 in baud");

    property p_capture;
        (t2_mode == T2_CAPT && !sfr_wr_i) and s_trig_fall
            |=> rcl_ff == $past(tl2_ff) && rch_ff == $past(th2_ff) && timer_two_control_ff[T2_TIMER_TWO_EXTERNAL_FLAG];
    endproperty
    a_capture: assert property (p_capture) else $error("capture failed");

    property p_wr_prio;
        sfr_wr_i && sfr_addr_i == TCB_A_TL0 |=> tl0_ff == $past(sfr_wdata_i);
    endproperty
    a_wr_prio: assert property (p_wr_prio) else $error("write lost");

endmodule

`default_nettype wire
